// ===== shared/rbk_pkg.sv
// register bank package: offsets, bit positions, per-register init tables
// assumes an 8-bit core whose special registers sit behind an APB slave
`default_nettype none
package rbk_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int unsigned RBK_AW        = 12;  // apb address width
	localparam int unsigned RBK_SLOTS     = 22;  // control/status slots
	localparam logic [3:0]  RBK_PAGE_CORE = 4'h0; // core space page
	localparam logic [3:0]  RBK_PAGE_CTRL = 4'h1; // control space page
	localparam logic [5:0]  RBK_IDX_FIRST = 6'h03; // first core index
	localparam logic [5:0]  RBK_IDX_RAM0  = 6'h10; // first ram index
	localparam logic [5:0]  RBK_IDX_RAM1  = 6'h2F; // last ram index
	localparam logic [5:0]  RBK_IDX_CTL0  = 6'h0A; // first control index
	localparam logic [5:0]  RBK_IDX_CTL1  = 6'h0F; // last control index
	localparam logic [4:0]  RBK_CTL_SLOT0 = 5'h10; // slot of control 0x0A

	// slot numbers of registers that hardware also touches
	localparam int unsigned RBK_S_STATUS  = 3;
	localparam int unsigned RBK_S_BANK    = 4;
	localparam int unsigned RBK_S_PORTA   = 5;
	localparam int unsigned RBK_S_PORTB   = 6;
	localparam int unsigned RBK_S_PORTC   = 7;
	localparam int unsigned RBK_S_WAKE    = 10;
	localparam int unsigned RBK_S_EECTL   = 11;
	localparam int unsigned RBK_S_EEADR   = 12;
	localparam int unsigned RBK_S_EEDAT   = 13;
	localparam int unsigned RBK_S_LVCTL   = 14;
	localparam int unsigned RBK_S_FLAGS   = 15;
	localparam int unsigned RBK_S_CTLA    = 16;
	localparam int unsigned RBK_S_PDOFF   = 17;
	localparam int unsigned RBK_S_ODEN    = 18;
	localparam int unsigned RBK_S_PHOFF   = 19;
	localparam int unsigned RBK_S_WDOG    = 20;
	localparam int unsigned RBK_S_MASK    = 21;

	// ----------------------------------------------------------------
	// bit positions
	// ----------------------------------------------------------------
	localparam int unsigned RBK_B_TIMEOUT  = 4; // status timeout flag
	localparam int unsigned RBK_B_PWRDOWN  = 3; // status power-down flag
	localparam int unsigned RBK_B_LV_N     = 2; // lowvolt_status_n
	localparam int unsigned RBK_B_LV_EN    = 3; // lowvolt_enable
	localparam int unsigned RBK_B_LV_IRQ   = 7; // lowvolt_irq_flag
	localparam int unsigned RBK_B_EXT_IRQ  = 2; // ext_irq_flag
	localparam int unsigned RBK_B_PC_IRQ   = 1; // pin_change_irq_flag
	localparam int unsigned RBK_B_TMR_IRQ  = 0; // timer_irq_flag

	// ----------------------------------------------------------------
	// per-register init pattern
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       impl;      // slot exists
		logic [7:0] por;       // power-on value (undefined bits as 0)
		logic [7:0] warm_keep; // bits kept on pin or watchdog reset
		logic [7:0] warm_set;  // bits forced to one on that reset
		logic [7:0] wake_keep; // bits kept on pin-change wake-up
		logic [7:0] wake_set;  // bits forced to one on wake-up
		logic [7:0] wr_mask;   // software-writable bits
	} rbk_init_t;

	localparam rbk_init_t RBK_INIT [RBK_SLOTS] = '{
		'{1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, // 0 none
		'{1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, // 1 none
		'{1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, // 2 none
		'{1'b1, 8'h18, 8'h07, 8'h00, 8'hFF, 8'h00, 8'hE7}, // core_status
		'{1'b1, 8'h00, 8'h3F, 8'h00, 8'h3F, 8'h00, 8'hFF}, // bank_select
		'{1'b1, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF}, // port_a_data
		'{1'b1, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF}, // port_b_data
		'{1'b1, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80}, // port_c_data
		'{1'b1, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF}, // spare 8
		'{1'b1, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF}, // spare 9
		'{1'b1, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h40}, // wake_control
		'{1'b1, 8'h00, 8'hF8, 8'h00, 8'hF8, 8'h00, 8'hF8}, // eeprom_control
		'{1'b1, 8'h00, 8'h7F, 8'h00, 8'h7F, 8'h00, 8'h7F}, // eeprom_address
		'{1'b1, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF}, // eeprom_data
		'{1'b1, 8'h04, 8'h00, 8'h04, 8'h0F, 8'h00, 8'h0B}, // low_voltage
		'{1'b1, 8'h00, 8'h00, 8'h00, 8'h87, 8'h00, 8'h87}, // interrupt_flags
		'{1'b1, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF}, // control_a
		'{1'b1, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF}, // pulldown_disable
		'{1'b1, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF}, // open_drain
		'{1'b1, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF}, // pullhigh_disable
		'{1'b1, 8'h8F, 8'h00, 8'h8F, 8'h5F, 8'h80, 8'hDF}, // watchdog_prescale
		'{1'b1, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h07}  // interrupt_mask
	};

	// reset-cause event handed from the cause decoder to the bank
	typedef struct packed {
		logic apply_warm; // pin or watchdog reset pattern
		logic apply_wake; // pin-change wake-up pattern
		logic t_keep;     // keep timeout flag
		logic t_val;      // timeout flag value otherwise
		logic p_keep;     // keep power-down flag
		logic p_val;      // power-down flag value otherwise
	} rbk_event_t;

	// register contents seen by the rest of the core
	typedef struct packed {
		logic [7:0] core_status;
		logic [7:0] bank_select;
		logic [7:0] port_a_data;
		logic [7:0] port_b_data;
		logic [7:0] port_c_data;
		logic [7:0] wake_control;
		logic [7:0] eeprom_control;
		logic [7:0] eeprom_address;
		logic [7:0] eeprom_data;
		logic [7:0] low_voltage_control;
		logic [7:0] interrupt_flags;
		logic [7:0] control_a;
		logic [7:0] pulldown_disable;
		logic [7:0] open_drain_enable;
		logic [7:0] pullhigh_disable;
		logic [7:0] watchdog_prescale_control;
		logic [7:0] interrupt_mask;
	} rbk_regs_t;

endpackage
`default_nettype wire

// ===== hdl/rbk_ram.sv
// general-purpose ram: 32 bytes, registered read, no reset
// assumes one write or one read per cycle from the bus slave
`default_nettype none
module rbk_ram (
	input  wire logic       pclk,    // core clock
	input  wire logic       we,      // write strobe
	input  wire logic       re,      // read strobe
	input  wire logic [4:0] addr,    // byte index
	input  wire logic [7:0] wdata,   // write byte
	output var  logic [7:0] rdata    // read byte, one cycle after re
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] mem [32]; // no reset: contents survive every warm reset

	// write and registered read
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata <= mem[addr];
		end
	end
endmodule // rbk_ram
`default_nettype wire

// ===== hdl/rbk_cause.sv
// reset-cause decoder: turns pin reset, watchdog and wake events into
// one registered pattern-select event with timeout/power-down values
// assumes wdt_timeout, pin_wake and in_sleep come from pclk logic
`default_nettype none
module rbk_cause
	import rbk_pkg::*;
(
	input  wire logic       pclk,        // core clock
	input  wire logic       presetn,     // power-on reset, active low
	input  wire logic       ext_reset_n, // reset pin, asynchronous
	input  wire logic       wdt_timeout, // watchdog timeout pulse
	input  wire logic       pin_wake,    // pin-change wake pulse
	input  wire logic       in_sleep,    // core is sleeping
	output var  rbk_event_t evt          // one-cycle cause event
);
	// ----------------------------------------------------------------
	// pin synchroniser and edge
	// ----------------------------------------------------------------
	logic pin_s1;     // first stage, read only by pin_s2
	logic pin_s2;     // synchronised pin level
	logic pin_prev;   // last synced level
	logic slept;      // core was asleep when the pin fell
	rbk_event_t next_evt;
	wire  pin_fall = pin_prev & ~pin_s2;
	wire  pin_rise = ~pin_prev & pin_s2;

	// decode: release of the pin first, then watchdog, then wake
	always_comb begin
		next_evt = '0;
		if (pin_rise) begin
			next_evt.apply_warm = 1'b1;
			next_evt.t_keep     = ~slept;
			next_evt.p_keep     = ~slept;
			next_evt.t_val      = 1'b1;
			next_evt.p_val      = 1'b0;
		end else if (wdt_timeout && pin_s2) begin
			next_evt.apply_warm = 1'b1;
			next_evt.t_val      = 1'b0;
			next_evt.p_keep     = ~in_sleep;
			next_evt.p_val      = 1'b0;
		end else if (pin_wake && pin_s2) begin
			next_evt.apply_wake = 1'b1;
			next_evt.t_val      = 1'b1;
			next_evt.p_val      = 1'b0;
		end
	end

	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1   <= 1'b1;
			pin_s2   <= 1'b1;
			pin_prev <= 1'b1;
			slept    <= 1'b0;
			evt      <= '0;
		end else begin
			pin_s1   <= ext_reset_n;
			pin_s2   <= pin_s1;
			pin_prev <= pin_s2;
			slept    <= pin_fall ? in_sleep : slept;
			evt      <= next_evt;
		end
	end
endmodule // rbk_cause
`default_nettype wire

// ===== hdl/rbk_bank.sv
// reset-aware special register bank of an 8-bit core, apb slave
// assumes apb3/apb4 master on pclk; reset pin arrives asynchronously
`default_nettype none
module rbk_bank
	import rbk_pkg::*;
(
	input  wire logic                 pclk,        // core clock
	input  wire logic                 presetn,     // power-on reset
	input  wire logic                 psel,        // apb select
	input  wire logic                 penable,     // apb access phase
	input  wire logic                 pwrite,      // apb direction
	input  wire logic [RBK_AW-1:0]    paddr,       // apb byte address
	input  wire logic [31:0]          pwdata,      // apb write data
	input  wire logic [3:0]           pstrb,       // apb byte strobes
	output var  logic                 pready,      // apb ready
	output var  logic                 pslverr,     // apb error
	output var  logic [31:0]          prdata,      // apb read data
	input  wire logic                 ext_reset_n, // reset pin
	input  wire logic                 wdt_timeout, // watchdog timeout
	input  wire logic                 pin_wake,    // pin-change wake
	input  wire logic                 in_sleep,    // core sleeping
	input  wire logic                 ext_irq_evt, // external irq event
	input  wire logic                 pc_irq_evt,  // pin-change event
	input  wire logic                 tmr_irq_evt, // timer overflow
	input  wire logic                 lv_below,    // supply below level
	output var  rbk_pkg::rbk_regs_t   regs         // register contents
);
	import rbk_pkg::*;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// slot lookup: bit 5 says hit, bits 4..0 say which slot
	function automatic logic [5:0] slot_of(input logic [RBK_AW-1:0] a);
		logic [5:0] idx;
		logic [3:0] page;
		idx  = a[7:2];
		page = a[11:8];
		if (a[1:0] != 2'b00) begin
			slot_of = 6'h00;
		end else if (page == RBK_PAGE_CORE && idx >= RBK_IDX_FIRST &&
			idx < RBK_IDX_RAM0) begin
			slot_of = {1'b1, idx[4:0]};
		end else if (page == RBK_PAGE_CTRL && idx >= RBK_IDX_CTL0 &&
			idx <= RBK_IDX_CTL1) begin
			slot_of = {1'b1, RBK_CTL_SLOT0 + 5'(idx - RBK_IDX_CTL0)};
		end else begin
			slot_of = 6'h00;
		end
	endfunction

	// keep-and-force pattern: the heart of the warm and wake-up resets
	function automatic logic [7:0] pattern(input logic [7:0] q,
		input logic [7:0] keep, input logic [7:0] set);
		pattern = (q & keep) | set;
	endfunction

	wire  [5:0] slot_hit = slot_of(paddr);        // register decode
	wire        reg_hit  = slot_hit[5];           // a register slot
	wire  [4:0] slot     = slot_hit[4:0];         // which slot
	wire        ram_hit  = paddr[11:8] == RBK_PAGE_CORE &&
		paddr[1:0] == 2'b00 && paddr[7:2] >= RBK_IDX_RAM0 &&
		paddr[7:2] <= RBK_IDX_RAM1;               // general ram
	wire  [4:0] ram_addr = {paddr[7], paddr[5:2]}; // ram index
	wire        any_hit  = reg_hit | ram_hit;     // mapped at all
	wire        setup    = psel & ~penable;       // apb setup cycle
	wire        access   = psel & penable;        // apb access cycle
	wire        wr_go    = access & pwrite & pstrb[0]; // byte 0 lane
	wire        reg_wr   = wr_go & reg_hit;       // register write
	wire        ram_wr   = wr_go & ram_hit;       // ram write
	wire        ram_rd   = setup & ~pwrite & ram_hit; // ram read

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] q [RBK_SLOTS];       // register slots
	logic [7:0] next_q [RBK_SLOTS];  // next slot values
	logic [7:0] rd_q;                // latched register read byte
	logic       ram_sel;             // current read targets ram
	logic [7:0] ram_q;               // ram read byte
	logic       lv_s1;               // supply sync, first stage
	logic       lv_s2;               // supply sync, second stage
	rbk_event_t evt;                 // decoded reset cause
	logic [7:0] irq_set;             // hardware flag sets
	logic [7:0] rd_mux;              // register read selection

	// ----------------------------------------------------------------
	// reset cause and memory
	// ----------------------------------------------------------------
	// cause decoder hands one event per reset kind
	rbk_cause u_cause (
		.pclk        (pclk),
		.presetn     (presetn),
		.ext_reset_n (ext_reset_n),
		.wdt_timeout (wdt_timeout),
		.pin_wake    (pin_wake),
		.in_sleep    (in_sleep),
		.evt         (evt)
	);

	// ram has no reset: undefined at power-on, kept otherwise
	rbk_ram u_ram (
		.pclk  (pclk),
		.we    (ram_wr),
		.re    (ram_rd),
		.addr  (ram_addr),
		.wdata (pwdata[7:0]),
		.rdata (ram_q)
	);

	// ----------------------------------------------------------------
	// hardware flag sources
	// ----------------------------------------------------------------
	// flags are set whatever the mask says; set wins over a clear
	always_comb begin
		irq_set                = 8'h00;
		irq_set[RBK_B_LV_IRQ]  = lv_s2 & q[RBK_S_LVCTL][RBK_B_LV_EN];
		irq_set[RBK_B_EXT_IRQ] = ext_irq_evt;
		irq_set[RBK_B_PC_IRQ]  = pc_irq_evt;
		irq_set[RBK_B_TMR_IRQ] = tmr_irq_evt;
	end

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	// reset pattern beats a software write in the same cycle, since
	// the core is being reset and its last store must not survive
	always_comb begin
		for (int i = 0; i < RBK_SLOTS; i++) begin
			next_q[i] = q[i];
			if (!RBK_INIT[i].impl) begin
				next_q[i] = 8'h00;
			end else if (evt.apply_warm) begin
				// warm patterns cover rules 1,3..18 by table
				next_q[i] = pattern(q[i], RBK_INIT[i].warm_keep,
					RBK_INIT[i].warm_set);
			end else if (evt.apply_wake) begin
				next_q[i] = pattern(q[i], RBK_INIT[i].wake_keep,
					RBK_INIT[i].wake_set);
			end else if (reg_wr && slot == 5'(i)) begin
				next_q[i] = (q[i] & ~RBK_INIT[i].wr_mask) |
					(pwdata[7:0] & RBK_INIT[i].wr_mask);
			end
		end
		// timeout and power-down follow the reset source
		if (evt.apply_warm || evt.apply_wake) begin
			next_q[RBK_S_STATUS][RBK_B_TIMEOUT] = evt.t_keep ?
				q[RBK_S_STATUS][RBK_B_TIMEOUT] : evt.t_val;
			next_q[RBK_S_STATUS][RBK_B_PWRDOWN] = evt.p_keep ?
				q[RBK_S_STATUS][RBK_B_PWRDOWN] : evt.p_val;
		end else begin
			// inverted detect status tracks the supply outside resets
			next_q[RBK_S_LVCTL][RBK_B_LV_N] = ~lv_s2;
		end
		// pin/watchdog reset clears the flags; events still land
		next_q[RBK_S_FLAGS] = next_q[RBK_S_FLAGS] | irq_set;
	end

	// ----------------------------------------------------------------
	// slot registers
	// ----------------------------------------------------------------
	// power-on loads each slot's table value; undefined bits read 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < RBK_SLOTS; i++) begin
				q[i] <= RBK_INIT[i].por;
			end
		end else begin
			for (int i = 0; i < RBK_SLOTS; i++) begin
				q[i] <= next_q[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// supply level synchroniser
	// ----------------------------------------------------------------
	// detector output is asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lv_s1 <= 1'b0;
			lv_s2 <= 1'b0;
		end else begin
			lv_s1 <= lv_below;
			lv_s2 <= lv_s1;
		end
	end

	// ----------------------------------------------------------------
	// apb read path
	// ----------------------------------------------------------------
	// unmapped or ram addresses give zero here
	assign rd_mux = reg_hit ? q[slot] : 8'h00;

	// read byte captured at setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q    <= 8'h00;
			ram_sel <= 1'b0;
		end else if (setup) begin
			rd_q    <= rd_mux;
			ram_sel <= ram_hit & ~pwrite;
		end
	end

	// no wait states: ram read completes during the setup cycle
	assign pready  = 1'b1;
	assign pslverr = access & ~any_hit;
	assign prdata  = {24'h000000, ram_sel ? ram_q : rd_q};

	// ----------------------------------------------------------------
	// register outputs
	// ----------------------------------------------------------------
	// page bits, flags and timeout bits come from the status slot
	assign regs.core_status    = q[RBK_S_STATUS];
	assign regs.bank_select    = q[RBK_S_BANK];
	assign regs.port_a_data    = q[RBK_S_PORTA];
	assign regs.port_b_data    = q[RBK_S_PORTB];
	assign regs.port_c_data    = q[RBK_S_PORTC];
	assign regs.wake_control   = q[RBK_S_WAKE];
	assign regs.eeprom_control = q[RBK_S_EECTL];
	assign regs.eeprom_address = q[RBK_S_EEADR];
	assign regs.eeprom_data    = q[RBK_S_EEDAT];
	assign regs.low_voltage_control = q[RBK_S_LVCTL];
	assign regs.interrupt_flags     = q[RBK_S_FLAGS];
	assign regs.control_a           = q[RBK_S_CTLA];
	assign regs.pulldown_disable    = q[RBK_S_PDOFF];
	assign regs.open_drain_enable   = q[RBK_S_ODEN];
	assign regs.pullhigh_disable    = q[RBK_S_PHOFF];
	// watchdog enable forced via set masks on warm and wake resets, via por at power-on
	assign regs.watchdog_prescale_control = q[RBK_S_WDOG];
	assign regs.interrupt_mask      = q[RBK_S_MASK];

endmodule // rbk_bank
`default_nettype wire

// ===== tb/rbk_bank_sva.sv
// checker of the register bank: reset patterns seen on the regs port
// assumes it is bound to rbk_bank and that event pulses last one cycle
`default_nettype none
module rbk_bank_sva
	import rbk_pkg::*;
(
	input wire logic               pclk,        // core clock
	input wire logic               presetn,     // power-on reset
	input wire logic               psel,        // apb select
	input wire logic               penable,     // apb access phase
	input wire logic               pslverr,     // apb error
	input wire logic               ext_reset_n, // reset pin
	input wire logic               wdt_timeout, // watchdog timeout
	input wire logic               pin_wake,    // pin-change wake
	input wire rbk_pkg::rbk_regs_t regs         // register contents
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic [4:0] hist; // recent pin levels
	// a pin release outranks the events, so judge only calm spells
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) hist <= 5'h00;
		else hist <= {hist[3:0], ext_reset_n};
	wire logic calm = ext_reset_n && (&hist); // pin high a while
	wire logic wd = wdt_timeout && calm; // watchdog reset taken
	wire logic wk = pin_wake && calm && !wdt_timeout; // wake taken
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_portc_low: assert property (regs.port_c_data[6:0] == 7'h00)
		else $error("port c low bits set");
	a_wake_bits: assert property (
		(regs.wake_control & 8'hBF) == 8'h00)
		else $error("wake control unused bits set");
	a_bank_top: assert property (wd || wk |-> ##2
		!regs.bank_select[7:6])
		else $error("bank select top bits kept");
	a_porta_kept: assert property (wd |-> ##2
		regs.port_a_data == $past(regs.port_a_data))
		else $error("port a lost on watchdog reset");
	a_odrain_clear: assert property (wd |-> ##2
		!regs.open_drain_enable)
		else $error("open drain not cleared");
	a_wdt_tflag: assert property (wd |-> ##2 !regs.core_status[4])
		else $error("timeout flag not cleared by watchdog");
	a_wake_tp: assert property (wk |-> ##2
		regs.core_status[4:3] == 2'b10)
		else $error("wake timeout/power-down wrong");
	a_wdog_warm: assert property (wd |-> ##2
		regs.watchdog_prescale_control == 8'h8F)
		else $error("watchdog control not defaulted");
	a_eeadr_kept: assert property (wd |-> ##2
		regs.eeprom_address == ($past(regs.eeprom_address) & 8'h7F))
		else $error("eeprom address not kept");
	c_wdt: cover property (wd);
	c_wake: cover property (wk);
	c_err: cover property (psel && penable && pslverr);
endmodule // rbk_bank_sva
bind rbk_bank rbk_bank_sva u_sva (
	.pclk, .presetn, .psel, .penable, .pslverr,
	.ext_reset_n, .wdt_timeout, .pin_wake, .regs
);
`default_nettype wire

// ===== tb/tb_rbk_bank.sv
// bench of the register bank: apb sweeps after each kind of reset
// assumes rbk_bank and its package; event inputs are one-cycle pulses
`default_nettype none
module tb_rbk_bank import rbk_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;       // tied: all lanes on
	logic        ext_reset_n, wdt_timeout, pin_wake, in_sleep;
	logic        ext_irq_evt, pc_irq_evt, tmr_irq_evt, lv_below;
	rbk_regs_t   regs;
	int          checked = 0, mismatches = 0, kd;
	logic [31:0] rs = 32'h9B37; // xorshift state
	logic [7:0]  c [20];        // contents before each event
	logic [32:0] q [$];         // expected {pslverr, prdata}
	// {page,0,index}, power-on, writable, warm keep/set, wake keep/set
	localparam logic [55:0] rm [20] = '{
		56'h03_18_E7_07_00_E7_00, 56'h04_00_FF_3F_00_3F_00,
		56'h05_00_FF_FF_00_FF_00, 56'h06_00_FF_FF_00_FF_00,
		56'h07_00_80_80_00_80_00, 56'h08_FF_FF_FF_00_FF_00,
		56'h0A_00_40_40_00_40_00, 56'h0B_00_F8_F8_00_F8_00,
		56'h0C_00_7F_7F_00_7F_00, 56'h0D_00_FF_FF_00_FF_00,
		56'h0E_04_0B_00_04_0F_00, 56'h0F_00_87_00_00_87_00,
		56'h8A_00_FF_00_00_FF_00, 56'h8B_FF_FF_00_FF_FF_00,
		56'h8C_00_FF_00_00_FF_00, 56'h8D_FF_FF_00_FF_FF_00,
		56'h8E_8F_DF_00_8F_5F_80, 56'h8F_00_07_00_00_07_00,
		56'h10_00_FF_FF_00_FF_00, 56'h2F_00_FF_FF_00_FF_00};
	rbk_bank dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .pslverr, .prdata, .ext_reset_n, .wdt_timeout, .pin_wake,
		.in_sleep, .ext_irq_evt, .pc_irq_evt, .tmr_irq_evt, .lv_below, .regs
	);
	always #2 pclk = ~pclk; // 250 MHz
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// byte address is four times the index, page in bit 8
	function automatic logic [11:0] ad(input logic [7:0] a);
		return {3'h0, a[7], a[5:0], 2'h0};
	endfunction
	task automatic cmp(input logic [32:0] e, input logic [32:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: want %h got %h", $time, e, g);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no wait-state count assumed: the watchdog ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read entries lo..hi-1 and note what kind kd should leave there
	task automatic sweep(input int lo, input int hi);
		logic [7:0] e;
		for (int i = lo; i < hi; i++) begin
			e = rm[i][47:40];
			if (kd == 3) e = (c[i] & rm[i][15:8]) | rm[i][7:0];
			else if (kd > 0) e = (c[i] & rm[i][31:24]) | rm[i][23:16];
			if (i == 0 && kd > 0)
				e = e | (kd == 5 ? 8'h00 : kd == 1 ? 8'h08 : 8'h10);
			if (kd > 0 || i < 18) begin // ram is undefined at power-on
				q.push_back({1'b0, 24'h0, e});
				xfer(1'b0, ad(rm[i][55:48]), 8'h00);
			end
		end
	endtask
	// random contents everywhere, then the external, pin-change and timer flag events
	task automatic load();
		for (int i = 0; i < 20; i++) begin
			rs = xs(rs);
			c[i] = (rs[7:0] & rm[i][39:32]) | (rm[i][47:40] & ~rm[i][39:32]);
			xfer(1'b1, ad(rm[i][55:48]), rs[7:0]);
		end
		@(posedge pclk);
		{ext_irq_evt, pc_irq_evt, tmr_irq_evt} <= 3'h7;
		@(posedge pclk);
		{ext_irq_evt, pc_irq_evt, tmr_irq_evt} <= 3'h0;
		c[11] = c[11] | 8'h07;
	endtask
	// 1 watchdog awake, 2 pin reset from sleep, 3 pin-change wake,
	// 4 pin reset awake (t/p kept), 5 watchdog asleep
	task automatic fire(input int kind);
		@(posedge pclk);
		in_sleep <= (kind != 1 && kind != 4);
		@(posedge pclk);
		if (kind == 1 || kind == 5) wdt_timeout <= 1'b1;
		else if (kind == 3) pin_wake <= 1'b1;
		else ext_reset_n <= 1'b0;
		@(posedge pclk);
		wdt_timeout <= 1'b0;
		pin_wake <= 1'b0;
		repeat (6) @(posedge pclk);
		ext_reset_n <= 1'b1;
		repeat (8) @(posedge pclk);
		in_sleep <= 1'b0;
	endtask
	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// stimulus, monitor, watchdog
	// ------------------------------------------------------------
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (q.size() > 0) cmp(q.pop_front(), {pslverr, prdata});
			else cmp(33'h0, 'x);
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, wdt_timeout, pin_wake} = '0;
		{in_sleep, ext_irq_evt, pc_irq_evt, tmr_irq_evt, lv_below} = '0;
		{paddr, pwdata} = '0;
		ext_reset_n = 1'b1;
		pstrb = 4'hF;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (kd = 0; kd < 6; kd++) begin
			if (kd > 0) begin
				load();
				fire(kd);
			end
			sweep(0, 5);
			sweep(5, 10);
			sweep(10, 15);
			sweep(15, 20);
		end
		q.push_back({1'b1, 32'h0}); // unmapped index reads zero with error
		xfer(1'b0, 12'h004, 8'h00);
		repeat (4) @(posedge pclk);
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		end_sim();
	end
endmodule // tb_rbk_bank
`default_nettype wire
